// ---- src/orm_mux.sv ----
// over-range flag outputs with optional reference clock copies or divide by 2 / 4 clocks on c and d
`default_nettype none
module orm_mux (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // device pins, asynchronous
    input wire logic [1:0] clock_out_strap,
    input wire logic pll_enable_pin,
    input wire logic power_down_pin,
    input wire logic ref_clock_diff_in,
    input wire logic ref_clock_se_in,
    input wire logic ref_select_se_pin,
    // register override settings
    input wire logic spi_clock_override,
    input wire logic spi_clock_disable,
    input wire logic [1:0] spi_cfg_c,
    input wire logic [1:0] spi_cfg_d,
    // converter core
    input wire logic [orm_pkg::SAMPLE_W-1:0] adc_sample_a,
    input wire logic [orm_pkg::SAMPLE_W-1:0] adc_sample_b,
    input wire logic [orm_pkg::SAMPLE_W-1:0] adc_sample_c,
    input wire logic [orm_pkg::SAMPLE_W-1:0] adc_sample_d,
    input wire logic [orm_pkg::SAMPLE_W-1:0] overrange_threshold,
    input wire logic [orm_pkg::HOLD_W-1:0] overrange_hold_count,
    // outputs
    output logic overrange_out_a,
    output logic overrange_out_b,
    output logic overrange_out_c,
    output logic overrange_out_d,
    output logic ref_clock_repeat_out
);
    function automatic orm_pkg::orm_src_t cfg_to_src(input logic [1:0] cfg);
        case (cfg)
            orm_pkg::CFG_COPY: cfg_to_src = orm_pkg::SRC_COPY;
            orm_pkg::CFG_DIV2: cfg_to_src = orm_pkg::SRC_DIV2;
            orm_pkg::CFG_DIV4: cfg_to_src = orm_pkg::SRC_DIV4;
            default: cfg_to_src = orm_pkg::SRC_FLAG;
        endcase
    endfunction : cfg_to_src

    // pin synchroniser
    logic [orm_pkg::PIN_W-1:0] sync1_reg;
    logic [orm_pkg::PIN_W-1:0] sync1_next;
    logic [orm_pkg::PIN_W-1:0] sync2_reg;
    logic [orm_pkg::PIN_W-1:0] sync2_next;
    logic [1:0] strap_s;
    logic pll_s;
    logic pd_s;
    logic ref_s;

    always_comb begin
        sync1_next = {ref_select_se_pin, ref_clock_se_in, ref_clock_diff_in,
                      power_down_pin, pll_enable_pin, clock_out_strap};
        sync2_next = sync1_reg;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            sync1_reg <= orm_pkg::PIN_RST;
            sync2_reg <= orm_pkg::PIN_RST;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
        end
    end

    always_comb begin
        strap_s = {sync2_reg[orm_pkg::PIN_STRAP1], sync2_reg[orm_pkg::PIN_STRAP0]};
        pll_s = sync2_reg[orm_pkg::PIN_PLL_EN];
        pd_s = sync2_reg[orm_pkg::PIN_PD];
        ref_s = sync2_reg[orm_pkg::PIN_REF_SEL] ? sync2_reg[orm_pkg::PIN_REF_SE]
                                                : sync2_reg[orm_pkg::PIN_REF_DIFF];
    end

    // over-range detection, one stretcher per channel
    logic [orm_pkg::SAMPLE_W-1:0] sample_arr [orm_pkg::NUM_CH];
    logic [orm_pkg::NUM_CH-1:0] flag;

    assign sample_arr[0] = adc_sample_a;
    assign sample_arr[1] = adc_sample_b;
    assign sample_arr[2] = adc_sample_c;
    assign sample_arr[3] = adc_sample_d;

    for (genvar i = 0; i < orm_pkg::NUM_CH; i++) begin : g_ch
        orm_hold u_hold (
            .mclk(mclk),
            .srst(srst),
            .sample(sample_arr[i]),
            .threshold(overrange_threshold),
            .hold_count(overrange_hold_count),
            .flag(flag[i])
        );
    end

    // reference edge detect and dividers
    logic ref_d_reg;
    logic ref_d_next;
    logic [1:0] div_cnt_reg;
    logic [1:0] div_cnt_next;
    logic ref_rise;

    always_comb begin
        ref_d_next = ref_s;
        ref_rise = ref_s && !ref_d_reg;
        div_cnt_next = ref_rise ? div_cnt_reg + 2'h1 : div_cnt_reg;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ref_d_reg <= 1'b0;
            div_cnt_reg <= orm_pkg::DIV_RST;
        end else begin
            ref_d_reg <= ref_d_next;
            div_cnt_reg <= div_cnt_next;
        end
    end

    // source selection for outputs c and d
    orm_pkg::orm_src_t c_src_reg;
    orm_pkg::orm_src_t c_src_next;
    orm_pkg::orm_src_t d_src_reg;
    orm_pkg::orm_src_t d_src_next;
    logic clk_allowed;
    logic [1:0] d_cfg;

    always_comb begin
        clk_allowed = pll_s && !pd_s && !spi_clock_disable;
        // straps act from reset with no register access
        c_src_next = cfg_to_src(spi_clock_override ? spi_cfg_c : strap_s);
        if (spi_clock_override) begin
            d_cfg = spi_cfg_d;
        end else begin
            d_cfg = (strap_s != 2'h0) ? orm_pkg::CFG_COPY : orm_pkg::CFG_FLAG;
        end
        d_src_next = cfg_to_src(d_cfg);
        if (!clk_allowed) begin
            c_src_next = orm_pkg::SRC_FLAG;
        end
        if (!clk_allowed || c_src_next == orm_pkg::SRC_FLAG) begin
            d_src_next = orm_pkg::SRC_FLAG;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            c_src_reg <= orm_pkg::SRC_FLAG;
            d_src_reg <= orm_pkg::SRC_FLAG;
        end else begin
            c_src_reg <= c_src_next;
            d_src_reg <= d_src_next;
        end
    end

    // output registers
    logic out_a_next;
    logic out_b_next;
    logic out_c_next;
    logic out_d_next;
    logic ref_out_next;
    logic out_a_reg;
    logic out_b_reg;
    logic out_c_reg;
    logic out_d_reg;
    logic ref_out_reg;

    function automatic logic pick(input orm_pkg::orm_src_t src, input logic flg,
                                  input logic refc, input logic [1:0] cnt);
        case (src)
            orm_pkg::SRC_COPY: pick = refc;
            orm_pkg::SRC_DIV2: pick = cnt[0];
            orm_pkg::SRC_DIV4: pick = cnt[1];
            default: pick = flg;
        endcase
    endfunction : pick

    always_comb begin
        out_a_next = flag[0];
        out_b_next = flag[1];
        out_c_next = pick(c_src_reg, flag[2], ref_s, div_cnt_reg);
        out_d_next = pick(d_src_reg, flag[3], ref_s, div_cnt_reg);
        ref_out_next = pll_s && !pd_s && ref_s;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            out_a_reg <= 1'b0;
            out_b_reg <= 1'b0;
            out_c_reg <= 1'b0;
            out_d_reg <= 1'b0;
            ref_out_reg <= 1'b0;
        end else begin
            out_a_reg <= out_a_next;
            out_b_reg <= out_b_next;
            out_c_reg <= out_c_next;
            out_d_reg <= out_d_next;
            ref_out_reg <= ref_out_next;
        end
    end

    assign overrange_out_a = out_a_reg;
    assign overrange_out_b = out_b_reg;
    assign overrange_out_c = out_c_reg;
    assign overrange_out_d = out_d_reg;
    assign ref_clock_repeat_out = ref_out_reg;

    // checks
    a_flag_rises: assert property (@(posedge mclk) disable iff (srst)
        (adc_sample_a > overrange_threshold) |-> ##2 overrange_out_a)
        else $error("channel a flag missed an over-range sample");

    a_flag_hold: assert property (@(posedge mclk) disable iff (srst)
        ($rose(overrange_out_b) && overrange_hold_count == 4'h3
         && $stable(overrange_hold_count)) |=> overrange_out_b ##1 overrange_out_b)
        else $error("channel b flag dropped before hold count");

    a_c_flag_path: assert property (@(posedge mclk) disable iff (srst)
        (c_src_reg == orm_pkg::SRC_FLAG) |=> overrange_out_c == $past(flag[2]))
        else $error("output c not carrying its flag");

    a_d_flag_path: assert property (@(posedge mclk) disable iff (srst)
        (d_src_reg == orm_pkg::SRC_FLAG) |=> overrange_out_d == $past(flag[3]))
        else $error("output d not carrying its flag");

    a_c_needs_pll: assert property (@(posedge mclk) disable iff (srst)
        (!pll_s || spi_clock_disable) |=> c_src_reg == orm_pkg::SRC_FLAG)
        else $error("output c became a clock without pll enable");

    a_c_div4: assert property (@(posedge mclk) disable iff (srst)
        (c_src_reg == orm_pkg::SRC_DIV4) |=> overrange_out_c == $past(div_cnt_reg[1]))
        else $error("output c divide by four wrong");

    a_d_strap_copy: assert property (@(posedge mclk) disable iff (srst)
        (!spi_clock_override && strap_s != 2'h0 && pll_s && !pd_s && !spi_clock_disable)
        |=> d_src_reg == orm_pkg::SRC_COPY)
        else $error("output d not copying reference under straps");

    a_d_div_spi: assert property (@(posedge mclk) disable iff (srst)
        (d_src_reg == orm_pkg::SRC_DIV2 || d_src_reg == orm_pkg::SRC_DIV4)
        |-> $past(spi_clock_override))
        else $error("output d divided without override");

    a_d_needs_c: assert property (@(posedge mclk) disable iff (srst)
        (d_src_reg != orm_pkg::SRC_FLAG) |-> c_src_reg != orm_pkg::SRC_FLAG)
        else $error("output d clock while c is a flag");

    a_pd_stops: assert property (@(posedge mclk) disable iff (srst)
        pd_s |=> !ref_clock_repeat_out && c_src_reg == orm_pkg::SRC_FLAG)
        else $error("power down did not stop clocks");

    a_div_step: assert property (@(posedge mclk) disable iff (srst)
        ref_rise |=> div_cnt_reg == 2'($past(div_cnt_reg) + 2'h1))
        else $error("divider did not step on reference edge");

    c_strap_start: cover property (@(posedge mclk) disable iff (srst)
        !spi_clock_override ##1 c_src_reg == orm_pkg::SRC_DIV2);
    c_d_copy: cover property (@(posedge mclk) disable iff (srst)
        d_src_reg == orm_pkg::SRC_COPY);
    c_d_div4: cover property (@(posedge mclk) disable iff (srst)
        d_src_reg == orm_pkg::SRC_DIV4);
    c_flag_pulse: cover property (@(posedge mclk) disable iff (srst)
        $rose(overrange_out_c) ##3 $fell(overrange_out_c));
endmodule : orm_mux
`default_nettype wire

// ---- include/orm_pkg.sv ----
// constants and types shared by the over-range / clock-out mux
`default_nettype none
package orm_pkg;
    localparam int SAMPLE_W = 9;
    localparam int HOLD_W = 4;
    localparam int CFG_W = 2;
    localparam int NUM_CH = 4;
    // clock configuration codes
    localparam logic [1:0] CFG_FLAG = 2'h0;
    localparam logic [1:0] CFG_COPY = 2'h1;
    localparam logic [1:0] CFG_DIV2 = 2'h2;
    localparam logic [1:0] CFG_DIV4 = 2'h3;
    // bit positions inside the pin synchroniser
    localparam int PIN_W = 7;
    localparam int PIN_STRAP0 = 0;
    localparam int PIN_STRAP1 = 1;
    localparam int PIN_PLL_EN = 2;
    localparam int PIN_PD = 3;
    localparam int PIN_REF_DIFF = 4;
    localparam int PIN_REF_SE = 5;
    localparam int PIN_REF_SEL = 6;
    // reset values
    localparam logic [PIN_W-1:0] PIN_RST = 7'h00;
    localparam logic [1:0] DIV_RST = 2'h0;
    localparam logic [HOLD_W-1:0] HOLD_RST = 4'h0;
    typedef enum {
        SRC_FLAG,
        SRC_COPY,
        SRC_DIV2,
        SRC_DIV4
    } orm_src_t;
endpackage : orm_pkg
`default_nettype wire

// ---- src/orm_hold.sv ----
// one channel of over-range detection with minimum pulse stretch
`default_nettype none
module orm_hold (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // sample and settings
    input wire logic [orm_pkg::SAMPLE_W-1:0] sample,
    input wire logic [orm_pkg::SAMPLE_W-1:0] threshold,
    input wire logic [orm_pkg::HOLD_W-1:0] hold_count,
    // stretched flag
    output logic flag
);
    logic flag_reg;
    logic flag_next;
    logic [orm_pkg::HOLD_W-1:0] cnt_reg;
    logic [orm_pkg::HOLD_W-1:0] cnt_next;
    logic exceed;

    always_comb begin
        exceed = sample > threshold;
        flag_next = exceed || (cnt_reg > 4'h1);
        if (exceed) begin
            cnt_next = hold_count;
        end else if (cnt_reg != 4'h0) begin
            cnt_next = cnt_reg - 4'h1;
        end else begin
            cnt_next = cnt_reg;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            flag_reg <= 1'b0;
            cnt_reg <= orm_pkg::HOLD_RST;
        end else begin
            flag_reg <= flag_next;
            cnt_reg <= cnt_next;
        end
    end

    assign flag = flag_reg;
endmodule : orm_hold
`default_nettype wire

// ---- bench/orm_fpga_rx.sv ----
// receiving logic model that measures clock periods arriving on the pins
`default_nettype none
module orm_fpga_rx (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // pins from the converter: ref repeat, out d, out c
    input wire logic [2:0] pin_in,
    // last period in mclk cycles, one byte a pin
    output logic [23:0] period
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] last_reg;
    logic [7:0] cnt_reg [3];
    // one clock is taken from pin c, pin d only for a second one
    always_ff @(posedge mclk) begin
        for (int i = 0; i < 3; i++) begin
            if (srst) begin
                cnt_reg[i] <= 8'h00;
                period[8*i +: 8] <= 8'h00;
            end else if (pin_in[i] && !last_reg[i]) begin
                period[8*i +: 8] <= cnt_reg[i] + 8'h01;
                cnt_reg[i] <= 8'h00;
            end else begin
                cnt_reg[i] <= cnt_reg[i] + 8'h01;
            end
        end
        last_reg <= pin_in;
    end
endmodule : orm_fpga_rx
`default_nettype wire

// ---- bench/overrange_flag_clock_out_mux_tb_top.sv ----
// self-checking bench for the over-range flag and clock-out mux
`default_nettype none
module overrange_flag_clock_out_mux_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    // {rsel, cfg_d, cfg_c, disable, override, pd, pll, strap}
    logic [10:0] mode = 11'h005;
    logic rdiff = 1'b0;
    logic rse = 1'b0;
    logic [8:0] smp [4] = '{default: 9'h000};
    logic [8:0] thr = 9'h100;
    logic [3:0] hold = 4'h3;
    logic [3:0] mask = 4'h0;
    logic [3:0] out;
    logic rep;
    logic [23:0] per;
    logic [15:0] hist [4];
    logic [10:0] fmode [4] = '{11'h004, 11'h003, 11'h037, 11'h054};
    logic [3:0] fmask [4] = '{4'hF, 4'hF, 4'hF, 4'hB};
    logic [3:0] fhold [4] = '{4'h0, 4'h3, 4'hF, 4'h7};
    logic [10:0] cmode [6] = '{11'h005, 11'h006, 11'h007, 11'h394, 11'h405, 11'h6D4};
    logic [23:0] cexp [6] = '{24'h080808, 24'h080810, 24'h080820, 24'h082010, 24'h0C0C0C,
        24'h0C1830};
    int seed = 32'h5853;
    int fails = 0;
    int compares = 0;
    int cyc = 0;

    orm_mux i_orm_mux (
        .mclk(mclk), .srst(srst), .clock_out_strap(mode[1:0]), .pll_enable_pin(mode[2]),
        .power_down_pin(mode[3]), .ref_clock_diff_in(rdiff), .ref_clock_se_in(rse),
        .ref_select_se_pin(mode[10]), .spi_clock_override(mode[4]),
        .spi_clock_disable(mode[5]), .spi_cfg_c(mode[7:6]), .spi_cfg_d(mode[9:8]),
        .adc_sample_a(smp[0]), .adc_sample_b(smp[1]), .adc_sample_c(smp[2]),
        .adc_sample_d(smp[3]), .overrange_threshold(thr), .overrange_hold_count(hold),
        .overrange_out_a(out[0]), .overrange_out_b(out[1]), .overrange_out_c(out[2]),
        .overrange_out_d(out[3]), .ref_clock_repeat_out(rep)
    );
    orm_fpga_rx i_orm_fpga_rx (.mclk(mclk), .srst(srst), .pin_in({rep, out[3], out[2]}),
        .period(per));

    always #25 mclk = ~mclk;

    // references: diff period 8 cycles, single-ended period 12 cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc % 4 == 3) rdiff <= ~rdiff;
        if (cyc % 6 == 5) rse <= ~rse;
        for (int i = 0; i < 4; i++) hist[i] <= srst ? 16'h0000 : {hist[i][14:0], smp[i] > thr};
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    // flag expected high if any exceed in the last max(hold,1) samples
    function automatic logic [7:0] exp_flag(input int ch);
        logic r;
        r = 1'b0;
        for (int k = 1; k < 16; k++) begin
            if (k <= ((hold == 4'h0) ? 1 : hold)) r = r | hist[ch][k];
        end
        return {7'h00, r};
    endfunction : exp_flag

    always @(negedge mclk) begin
        for (int i = 0; i < 4; i++) begin
            if (mask[i]) check("flag", exp_flag(i), {7'h00, out[i]});
        end
    end

    task automatic quiet(input logic [10:0] v, input logic [2:0] m);
        logic [2:0] seen;
        @(posedge mclk);
        mode <= v;
        repeat (20) @(posedge mclk);
        seen = 3'h0;
        repeat (60) begin
            @(negedge mclk);
            seen = seen | ({rep, out[3], out[2]} & m);
        end
        check("no_clock", 8'h00, {5'h00, seen});
    endtask : quiet

    task automatic complete_run();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        complete_run();
    end

    initial begin
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        // strapped clocks present from start-up, no override touched
        repeat (60) @(posedge mclk);
        #1;
        check("start_c", 8'h08, per[7:0]);
        check("start_d", 8'h08, per[15:8]);
        for (int m = 0; m < 4; m++) begin
            @(posedge mclk);
            mask <= 4'h3;
            mode <= fmode[m];
            hold <= fhold[m];
            thr <= 9'h008 + 9'($random(seed) & 32'h1F0);
            repeat (20) @(posedge mclk);
            mask <= fmask[m];
            repeat (300) begin
                @(posedge mclk);
                for (int i = 0; i < 4; i++) smp[i] <= thr - 9'h004 + 9'($random(seed) & 32'h7);
            end
            @(posedge mclk);
            for (int i = 0; i < 4; i++) smp[i] <= 9'h000;
            repeat (20) @(posedge mclk);
        end
        mask <= 4'h0;
        for (int m = 0; m < 6; m++) begin
            @(posedge mclk);
            mode <= cmode[m];
            repeat (120) @(posedge mclk);
            #1;
            check("period_c", cexp[m][7:0], per[7:0]);
            check("period_d", cexp[m][15:8], per[15:8]);
            check("period_ref", cexp[m][23:16], per[23:16]);
        end
        quiet(11'h00D, 3'h7);
        quiet(11'h114, 3'h3);
        complete_run();
    end
endmodule : overrange_flag_clock_out_mux_tb_top
`default_nettype wire
